// ---- reset_escalation_pkg.sv ----
/*
  Constants, state type and timing counts shared by the reset escalation
  control and its escalation counter.
  Assumes a 10 MHz system clock; all times are converted to clock cycles here.
*/
package reset_escalation_pkg;

  // Requested mode codes written to the mode control register
  localparam logic [3:0] MODE_FUNC_RESET = 4'h0;
  localparam logic [3:0] MODE_DESTR_RESET = 4'hF;

  // Escalation counter width and reset values of the thresholds
  localparam int CNT_W = 4;
  localparam logic [CNT_W-1:0] FUNC_THR_RESET = 4'h8;
  localparam logic [CNT_W-1:0] DESTR_THR_RESET = 4'h0;

  // Number of critical functional event inputs
  localparam int N_EVT = 8;

  // Alternative reaction encoding, one bit per event
  localparam logic ALT_IRQ = 1'h0;
  localparam logic ALT_NMI = 1'h1;

  // Clock and reset pulse timing
  localparam int CLK_PERIOD_NS = 100;
  localparam int FUNC_PULSE_NS = 1000;
  localparam int DESTR_PULSE_NS = 2000;
  localparam int FUNC_PULSE_CYC = (FUNC_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DESTR_PULSE_CYC = (DESTR_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TMR_W = 5;

  // Reset sequencer states, Gray coded along idle -> func -> destr
  typedef enum logic [1:0] {
    SEQ_IDLE = 2'h0,
    SEQ_FUNC = 2'h1,
    SEQ_DESTR = 2'h3
  } seq_state_t;

endpackage

// ---- esc_ctr_if.sv ----
/*
  Carrier between the sequencer and one escalation counter.
  Assumes a single clock domain; the counter owns count, thr and at_limit.
*/
`timescale 1ns/100ps
interface esc_ctr_if #(parameter int CNT_W = 4);
  logic inc;
  logic clr;
  logic thr_wr;
  logic [CNT_W-1:0] thr_data;
  logic [CNT_W-1:0] count;
  logic [CNT_W-1:0] thr;
  logic at_limit;

  modport seq (output inc, output clr, output thr_wr, output thr_data,
               input count, input thr, input at_limit);
  modport ctr (input inc, input clr, input thr_wr, input thr_data,
               output count, output thr, output at_limit);
endinterface

// ---- esc_counter.sv ----
/*
  Escalation counter with programmable threshold.
  Assumes the sequencer raises inc for one cycle per counted reset; a zero
  threshold disables escalation.
*/
`timescale 1ns/100ps
module esc_counter
  import reset_escalation_pkg::*;
#(
  parameter int W = 4,
  parameter logic [W-1:0] THR_INIT = '0
)
(
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Sequencer side
  esc_ctr_if.ctr port_c
);

  logic [W-1:0] count;
  logic [W-1:0] thr;
  logic [W-1:0] next_count;
  logic [W-1:0] next_thr;
  logic [W-1:0] base;

  // Clear first, then the increment, so a reset counted in the clearing
  // cycle is kept rather than lost
  always_comb
  begin
    base = (port_c.clr || port_c.thr_wr) ? '0 : count; // R5 R11
    next_thr = port_c.thr_wr ? port_c.thr_data : thr;
    if (port_c.inc && base != '1)
    begin
      next_count = base + W'(1); // R3
    end
    else
    begin
      next_count = base;
    end
  end

  // Power-on clears the count; threshold returns to its default
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      count <= '0; // R5
      thr <= THR_INIT; // R6 R7
    end
    else
    begin
      count <= next_count;
      thr <= next_thr;
    end
  end

  // Next counted reset reaches the threshold; zero threshold never hits
  assign port_c.at_limit = (thr != '0) && (count + W'(1) == thr); // R4 R6
  assign port_c.count = count;
  assign port_c.thr = thr;

endmodule

// ---- reset_escalation_control.sv ----
/*
  Reset generator: software mode requests, critical event reactions and
  functional / destructive reset escalation.
  Assumes all inputs are synchronous to clk, write strobes are one-cycle
  pulses and arst_n is the power-on reset.
*/
`timescale 1ns/100ps
// Contract
// R1 - Mode code zero starts a functional reset
// R2 - Mode code all ones starts destructive reset
// R3 - Count each functional reset while escalation enabled
// R4 - Count reaching threshold gives destructive reset instead
// R5 - Count cleared by software, destructive, power-on
// R6 - Destructive counting off until nonzero threshold written
// R7 - Functional escalation enabled straight after reset
// R8 - Event with disable bit zero launches reset
// R9 - Disabled event takes selected alternative reaction
// R10 - Software clears count after startup checks
// R11 - Threshold write restarts the functional count
module reset_escalation_control
  import reset_escalation_pkg::*;
#(
  parameter int NE = N_EVT
)
(
  // Clock and power-on reset
  input wire logic clk,
  input wire logic arst_n,
  // Mode control register write
  input wire logic mode_wr,
  input wire logic [3:0] mode_target,
  // Escalation threshold writes and count clears
  input wire logic func_thr_wr,
  input wire logic [CNT_W-1:0] func_thr_data,
  input wire logic func_count_clr,
  input wire logic destr_thr_wr,
  input wire logic [CNT_W-1:0] destr_thr_data,
  input wire logic destr_count_clr,
  // Event configuration registers
  input wire logic event_disable_wr,
  input wire logic [NE-1:0] event_disable_data,
  input wire logic event_alt_wr,
  input wire logic [NE-1:0] event_alt_data,
  // Critical functional events and status clear
  input wire logic [NE-1:0] event_in,
  input wire logic [NE-1:0] event_status_clr,
  // Reset outputs
  output logic func_reset,
  output logic destr_reset,
  output logic reset_halt,
  // Alternative reactions
  output logic alt_irq,
  output logic alt_nmi,
  // Status
  output logic [NE-1:0] event_status,
  output logic [NE-1:0] event_reset_disable_reg,
  output logic [NE-1:0] event_alt_reaction_reg,
  output logic [CNT_W-1:0] func_count,
  output logic [CNT_W-1:0] destr_count
);

  seq_state_t state;
  seq_state_t next_state;
  logic [TMR_W-1:0] tmr;
  logic [TMR_W-1:0] next_tmr;
  logic next_func_reset;
  logic next_destr_reset;
  logic next_reset_halt;
  logic next_alt_irq;
  logic next_alt_nmi;
  logic [NE-1:0] next_event_status;
  logic [NE-1:0] next_disable;
  logic [NE-1:0] next_alt;
  logic [NE-1:0] reset_events;
  logic [NE-1:0] alt_events;
  logic sw_func_req;
  logic sw_destr_req;
  logic func_req;
  logic destr_req;
  logic destr_start;

  esc_ctr_if #(.CNT_W(CNT_W)) func_if ();
  esc_ctr_if #(.CNT_W(CNT_W)) destr_if ();

  // Functional reset escalation counter, enabled from power-on
  esc_counter #(.W(CNT_W), .THR_INIT(FUNC_THR_RESET)) u_func_ctr
  (
    .clk(clk),
    .arst_n(arst_n),
    .port_c(func_if.ctr)
  );

  // Destructive reset counter, disabled until a nonzero threshold arrives
  esc_counter #(.W(CNT_W), .THR_INIT(DESTR_THR_RESET)) u_destr_ctr
  (
    .clk(clk),
    .arst_n(arst_n),
    .port_c(destr_if.ctr)
  );

  // Split events into reset launchers and alternative reactions
  always_comb
  begin
    reset_events = event_in & ~event_reset_disable_reg; // R8
    alt_events = event_in & event_reset_disable_reg; // R9
    sw_func_req = mode_wr && (mode_target == MODE_FUNC_RESET); // R1
    sw_destr_req = mode_wr && (mode_target == MODE_DESTR_RESET); // R2
    func_req = sw_func_req || (|reset_events);
    // A functional request that reaches the threshold escalates
    destr_req = sw_destr_req || (func_req && func_if.at_limit); // R4
  end

  // Sequencer: requests are taken only in idle; destructive wins
  always_comb
  begin
    next_state = state;
    next_tmr = tmr;
    func_if.inc = 1'b0;
    destr_start = 1'b0;
    next_reset_halt = reset_halt;
    unique case (state)
      SEQ_IDLE:
      begin
        if (destr_req && !reset_halt)
        begin
          next_state = SEQ_DESTR;
          next_tmr = TMR_W'(DESTR_PULSE_CYC - 1);
          destr_start = 1'b1;
          // Last allowed destructive reset: hold the device in reset
          if (destr_if.at_limit)
          begin
            next_reset_halt = 1'b1; // R6
          end
        end
        else if (func_req && !reset_halt)
        begin
          next_state = SEQ_FUNC;
          next_tmr = TMR_W'(FUNC_PULSE_CYC - 1);
          func_if.inc = 1'b1; // R3 R7
        end
      end
      SEQ_FUNC, SEQ_DESTR:
      begin
        if (tmr == '0)
        begin
          next_state = SEQ_IDLE;
        end
        else
        begin
          next_tmr = tmr - TMR_W'(1);
        end
      end
      default:
      begin
        next_state = SEQ_IDLE;
      end
    endcase
    next_func_reset = (next_state == SEQ_FUNC);
    next_destr_reset = (next_state == SEQ_DESTR) || next_reset_halt;
  end

  // Counter control: software clears, destructive entry clears functional
  always_comb
  begin
    // Every destructive start clears the functional count, but the
    // destructive count only moves once a nonzero threshold enables it
    func_if.clr = func_count_clr || destr_start; // R5 R10
    destr_if.inc = destr_start && (destr_if.thr != '0); // R6
    func_if.thr_wr = func_thr_wr; // R11
    func_if.thr_data = func_thr_data;
    destr_if.clr = destr_count_clr;
    destr_if.thr_wr = destr_thr_wr; // R6
    destr_if.thr_data = destr_thr_data;
  end

  // Event configuration, status and alternative reaction pulses
  always_comb
  begin
    next_disable = event_disable_wr ? event_disable_data : event_reset_disable_reg;
    next_alt = event_alt_wr ? event_alt_data : event_alt_reaction_reg;
    // Set wins over clear so an event in the clearing cycle stays visible
    next_event_status = (event_status & ~event_status_clr) | event_in;
    next_alt_irq = |(alt_events & ~event_alt_reaction_reg); // R9
    next_alt_nmi = |(alt_events & event_alt_reaction_reg); // R9
  end

  // Sequencer and output registers
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state <= SEQ_IDLE;
      tmr <= '0;
      func_reset <= 1'b0;
      destr_reset <= 1'b0;
      reset_halt <= 1'b0;
    end
    else
    begin
      state <= next_state;
      tmr <= next_tmr;
      func_reset <= next_func_reset;
      destr_reset <= next_destr_reset;
      reset_halt <= next_reset_halt;
    end
  end

  // Configuration defaults to all events launching a reset
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      event_reset_disable_reg <= '0;
      event_alt_reaction_reg <= '0;
      event_status <= '0;
      alt_irq <= 1'b0;
      alt_nmi <= 1'b0;
    end
    else
    begin
      event_reset_disable_reg <= next_disable;
      event_alt_reaction_reg <= next_alt;
      event_status <= next_event_status;
      alt_irq <= next_alt_irq;
      alt_nmi <= next_alt_nmi;
    end
  end

  // Counts come straight from the counter flip-flops
  assign func_count = func_if.count;
  assign destr_count = destr_if.count;

endmodule

// ---- reset_escalation_control_props.sv ----
/* Port checker for reset_escalation_control, bound to every instance.
   Assumes one clock and arst_n as active-low power-on reset. */
`timescale 1ns/100ps
module reset_escalation_control_props
  import reset_escalation_pkg::*;
#(
  parameter int NE = N_EVT
)
(
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Requests
  input wire logic mode_wr,
  input wire logic [3:0] mode_target,
  input wire logic func_thr_wr,
  input wire logic func_count_clr,
  input wire logic [NE-1:0] event_in,
  // Responses
  input wire logic func_reset,
  input wire logic destr_reset,
  input wire logic reset_halt,
  input wire logic alt_irq,
  input wire logic alt_nmi,
  input wire logic [NE-1:0] event_reset_disable_reg,
  input wire logic [NE-1:0] event_alt_reaction_reg,
  input wire logic [CNT_W-1:0] func_count
);
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  // Requests are only taken while no sequence runs
  logic idle;
  logic [NE-1:0] trig;
  assign idle = !func_reset && !destr_reset && !reset_halt;
  assign trig = event_in & ~event_reset_disable_reg;
  mode_func_a: assert property (
    idle && mode_wr && mode_target == 4'h0 |=> func_reset || destr_reset)
    else $error("functional request not taken");
  mode_destr_a: assert property (
    idle && mode_wr && mode_target == 4'hF |=> destr_reset) else $error("no destructive reset");
  func_len_a: assert property (
    $rose(func_reset) |-> func_reset[*5] ##1 func_reset[*5] ##1 !func_reset)
    else $error("functional pulse length wrong");
  count_step_a: assert property (
    $rose(func_reset) && !$past(func_thr_wr) && !$past(func_count_clr) && $past(func_count) != 4'hF
    |-> func_count == $past(func_count) + 4'h1) else $error("count did not step");
  destr_clear_a: assert property (
    $rose(destr_reset) |-> func_count == 4'h0) else $error("count kept over destructive");
  sw_clear_a: assert property (
    func_thr_wr || func_count_clr |=> func_count <= 4'h1) else $error("count not cleared");
  evt_reset_a: assert property (
    idle && trig != '0 |=> func_reset || destr_reset) else $error("event gave no reset");
  evt_irq_a: assert property (
    (event_in & event_reset_disable_reg & ~event_alt_reaction_reg) != '0 |=> alt_irq)
    else $error("no alternative irq");
  evt_nmi_a: assert property (
    (event_in & event_reset_disable_reg & event_alt_reaction_reg) != '0 |=> alt_nmi)
    else $error("no alternative nmi");
  no_reset_a: assert property (
    idle && !mode_wr && trig == '0 |=> !func_reset && !destr_reset) else $error("stray reset");
endmodule

bind reset_escalation_control reset_escalation_control_props #(.NE(NE)) i_props (.*);

// ---- tb_reset_escalation_control.sv ----
/* Directed testbench for reset_escalation_control.
   Assumes inputs driven on falling edges of a 10 MHz clock. */
`timescale 1ns/100ps
module tb_reset_escalation_control;
  import reset_escalation_pkg::*;
  logic clk, arst_n, mode_wr, func_thr_wr, func_count_clr, destr_thr_wr, destr_count_clr;
  logic event_disable_wr, event_alt_wr, func_reset, destr_reset, reset_halt, alt_irq, alt_nmi;
  logic [3:0] mode_target, func_thr_data, destr_thr_data, func_count, destr_count;
  logic [7:0] event_disable_data, event_alt_data, event_in, event_status_clr, event_status;
  logic [7:0] event_reset_disable_reg, event_alt_reaction_reg;
  int error_cnt, n_checks, n;
  reset_escalation_control i_dut (.*);

  // Free running clock, 100 ns period
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // Case equality so an unknown never matches
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic complete_run;
    $display("checks=%0d mismatches=%0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // One-cycle mode write; returns where the answer is settled
  task automatic req(input logic [3:0] m);
    mode_target = m;
    mode_wr = 1'b1;
    @(negedge clk);
    mode_wr = 1'b0;
  endtask

  // Bounded wait for the sequencer; n is how long the reset stood
  task automatic wait_idle;
    n = 0;
    while ((func_reset || destr_reset) && n < 40)
    begin
      @(negedge clk);
      n++;
    end
    if (n == 40)
    begin
      error_cnt++;
      complete_run;
    end
  endtask

  task automatic t_func;
    req(4'h5);
    chk(func_reset, 8'h00);
    @(negedge clk);
    req(4'h0);
    chk({destr_reset, func_reset}, 8'h01);
    chk(func_count, 8'h01);
    wait_idle;
    chk(n[7:0], 8'h0A);
    $display("functional request done");
  endtask

  // Default threshold with no setup: eighth request escalates
  task automatic t_escal;
    func_count_clr = 1'b1;
    @(negedge clk);
    func_count_clr = 1'b0;
    chk(func_count, 8'h00);
    repeat (7)
    begin
      req(4'h0);
      wait_idle;
    end
    chk(func_count, 8'h07);
    req(4'h0);
    chk({destr_reset, func_reset, func_count}, 8'h20);
    wait_idle;
    chk(n[7:0], 8'h14);
    chk(destr_count, 8'h00);
    $display("escalation done");
  endtask

  task automatic t_thr;
    req(4'h0);
    wait_idle;
    func_thr_data = 4'h2;
    func_thr_wr = 1'b1;
    @(negedge clk);
    func_thr_wr = 1'b0;
    chk(func_count, 8'h00);
    req(4'h0);
    chk(func_count, 8'h01);
    wait_idle;
    req(4'h0);
    chk({destr_reset, func_reset}, 8'h02);
    wait_idle;
    $display("threshold write done");
  endtask

  // Bits 0 and 1 disabled: irq, nmi; bit 2 resets
  task automatic t_event;
    logic [7:0] exp[3] = '{8'h04, 8'h08, 8'h01};
    event_disable_data = 8'h03;
    event_alt_data = 8'h02;
    {event_disable_wr, event_alt_wr} = 2'h3;
    @(negedge clk);
    {event_disable_wr, event_alt_wr} = 2'h0;
    chk(event_reset_disable_reg, 8'h03);
    for (int i = 0; i < 3; i++)
    begin
      event_in = 8'h01 << i;
      @(negedge clk);
      event_in = 8'h00;
      chk({alt_nmi, alt_irq, destr_reset, func_reset}, exp[i]);
      wait_idle;
      @(negedge clk);
    end
    chk(event_alt_reaction_reg, 8'h02);
    chk(event_status, 8'h07);
    // Set wins when an event lands in the clearing cycle
    event_status_clr = 8'h03;
    event_in = 8'h01;
    @(negedge clk);
    {event_status_clr, event_in} = '0;
    chk(event_status, 8'h05);
    $display("events done");
  endtask

  task automatic t_destr;
    destr_thr_data = 4'h2;
    destr_thr_wr = 1'b1;
    @(negedge clk);
    destr_thr_wr = 1'b0;
    req(4'hF);
    chk({destr_count, 3'h0, destr_reset}, 8'h11);
    wait_idle;
    destr_count_clr = 1'b1;
    @(negedge clk);
    destr_count_clr = 1'b0;
    chk(destr_count, 8'h00);
    req(4'hF);
    chk({destr_count, 3'h0, reset_halt}, 8'h10);
    wait_idle;
    req(4'hF);
    chk(reset_halt, 8'h01);
    arst_n = 1'b0;
    @(negedge clk);
    arst_n = 1'b1;
    @(negedge clk);
    chk({destr_count, func_count}, 8'h00);
    $display("destructive done");
  endtask

  // Main sequence: reset, then scenarios
  initial
  begin
    {mode_wr, func_thr_wr, func_count_clr, destr_thr_wr, destr_count_clr} = '0;
    {event_disable_wr, event_alt_wr, event_in, event_status_clr} = '0;
    {mode_target, func_thr_data, destr_thr_data, event_disable_data, event_alt_data} = '0;
    arst_n = 1'b0;
    repeat (4) @(negedge clk);
    arst_n = 1'b1;
    @(negedge clk);
    chk({reset_halt, destr_count, func_count}, 8'h00);
    t_func;
    t_escal;
    t_thr;
    t_event;
    t_destr;
    complete_run;
  end
endmodule
